/* inc/acc_regs.svh */
// Register offsets, field positions, reset values and counts of the calibration and control block
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

`define ACC_OFS_CTRL     8'h00
`define ACC_OFS_OFFSET   8'h04
`define ACC_OFS_POS      8'h08
`define ACC_OFS_NEG      8'h0C
`define ACC_OFS_DATA     8'h10
`define ACC_OFS_STATUS   8'h14

`define ACC_MODE_HI      11
`define ACC_MODE_LO      9
`define ACC_GAIN_HI      7
`define ACC_GAIN_LO      5
`define ACC_STANDBY_BIT  3
`define ACC_BYTE_ORD_BIT 2

`define ACC_CTRL_RST     24'h000300
`define ACC_OFFSET_RST   24'h000000
`define ACC_FS_RST       24'h400000
`define ACC_COEFF_FRAC   22

`endif

/* inc/acc_pkg.sv */
// Types shared by the calibration and control block
package acc_pkg;

    typedef enum logic [2:0] {
        ACC_MODE_CONV    = 3'b000,
        ACC_MODE_SELF    = 3'b001,
        ACC_MODE_SYS_OFF = 3'b010,
        ACC_MODE_SYS_FS  = 3'b011
    } acc_mode_e;

    typedef enum logic [1:0] {
        ACC_ST_RUN      = 2'b00,
        ACC_ST_CAL_REQ  = 2'b01,
        ACC_ST_CAL_WAIT = 2'b10
    } acc_state_e;

    typedef struct packed {
        logic        done;
        logic [23:0] offset;
        logic [23:0] pos;
        logic [23:0] neg;
    } acc_cal_res_s;

    typedef struct packed {
        logic        valid;
        logic [23:0] data;
    } acc_sample_s;

endpackage

/* core/acc_byte_reg.sv */
// Byte-writable register with a hardware load port that wins over software
`timescale 1ns/1ps
module acc_byte_reg #(
    parameter int         W   = 24,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         wr_i,
    input  wire logic [W/8-1:0] sel_i,
    input  wire logic [W-1:0] wdat_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_dat_i,
    output logic      [W-1:0] q_o
);
    genvar b;
    generate
        for (b = 0; b < W/8; b++) begin : g_byte
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    q_o[b*8 +: 8] <= RST[b*8 +: 8];
                end else if (ce_i && load_i) begin
                    q_o[b*8 +: 8] <= load_dat_i[b*8 +: 8];
                end else if (ce_i && wr_i && sel_i[b]) begin
                    q_o[b*8 +: 8] <= wdat_i[b*8 +: 8];
                end
            end
        end
    endgenerate
endmodule // acc_byte_reg

/* core/acc_ctrl_cal.sv */
// Control register side effects, calibration coefficients and correction path behind a Wishbone slave
// Function
// [RULE_01] A write to control byte 2 or byte 1 drives the active-low result-valid output high.
// [RULE_02] Such a write with a calibration mode selected reruns that calibration before new data is delivered.
// [RULE_03] A write to control byte 0 alone neither raises result-valid nor starts a calibration; a byte 0 write that sets the standby bit drives it high here.
// [RULE_04] A host that changes gain through byte 0 alone must command a new calibration itself.
// [RULE_05] The host should rewrite the whole control register when changing gain.
// [RULE_06] A 24-bit offset coefficient is held and applied to the filter output.
// [RULE_07] After reset the offset coefficient is loaded with the self calibration result.
// [RULE_08] The offset coefficient makes the corrected output zero for a zero differential input.
// [RULE_09] A 24-bit positive full-scale coefficient sets the slope for positive results.
// [RULE_10] A 24-bit negative full-scale coefficient sets the slope for negative results.
// [RULE_11] After reset both full-scale coefficients are loaded with the self calibration results.
// [RULE_12] Each coefficient is accessed as byte 2 (bits 23:16), byte 1 (15:8) and byte 0 (7:0).
// [RULE_13] The active-low result-valid output goes low when a valid result waits in the data register.
// [RULE_14] The mode field is control bits 11 to 9 and resets to self calibration.
// [RULE_15] The gain field is control bits 7 to 5 and resets to a gain of one.
// [RULE_16] With the byte order bit set multi-byte registers appear in ascending byte order, else descending.
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_ctrl_cal (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire acc_pkg::acc_sample_s  raw_i,
    input  wire acc_pkg::acc_cal_res_s cal_res_i,
    output logic                      cal_start_o,
    output logic      [23:0]          ctrl_o,
    output logic                      result_valid_n_o
);
    localparam int FRAC = `ACC_COEFF_FRAC;

    acc_pkg::acc_state_e state_ff;
    acc_pkg::acc_state_e nxt_state;
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic [23:0] result_ff;
    logic        rvn_ff;
    logic        nxt_rvn;
    logic [23:0] ctrl_q;
    logic [23:0] off_q;
    logic [23:0] pos_q;
    logic [23:0] neg_q;

    function automatic logic [23:0] swap24(input logic [23:0] x);
        swap24 = {x[7:0], x[15:8], x[23:16]};
    endfunction

    function automatic logic is_cal(input logic [2:0] m);
        is_cal = (m == acc_pkg::ACC_MODE_SELF) || (m == acc_pkg::ACC_MODE_SYS_OFF) ||
                 (m == acc_pkg::ACC_MODE_SYS_FS);
    endfunction

    // Bus decode; a write lands only on the edge that also samples ack
    wire         req        = wb_cyc_i & wb_stb_i;
    wire         nxt_ack    = req & ~ack_ff;
    wire         wr_fire    = req & wb_we_i & ack_ff;
    wire         rd_fire    = req & ~wb_we_i & ack_ff;
    wire         byte_order_sel = ctrl_q[`ACC_BYTE_ORD_BIT];
    wire         hit_ctrl   = (wb_adr_i == `ACC_OFS_CTRL);
    wire         hit_off    = (wb_adr_i == `ACC_OFS_OFFSET);
    wire         hit_pos    = (wb_adr_i == `ACC_OFS_POS);
    wire         hit_neg    = (wb_adr_i == `ACC_OFS_NEG);
    wire         hit_data   = (wb_adr_i == `ACC_OFS_DATA);
    wire         hit_stat   = (wb_adr_i == `ACC_OFS_STATUS);
    // Lanes swap so that logical byte 2 is always bits 23:16 inside
    wire [2:0]   sel_l      = byte_order_sel ? {wb_sel_i[0], wb_sel_i[1], wb_sel_i[2]} : wb_sel_i[2:0]; // RULE_16
    wire [23:0]  wdat_l     = byte_order_sel ? swap24(wb_dat_i[23:0]) : wb_dat_i[23:0]; // RULE_16 RULE_12

    // Only the upper control bytes count as a reprogram; byte 0 alone is taken as a gain-only change
    wire         ctrl_hi_wr = wr_fire & hit_ctrl & (sel_l[2] | sel_l[1]); // RULE_01 RULE_03
    wire [2:0]   mode_now   = ctrl_q[`ACC_MODE_HI:`ACC_MODE_LO];
    wire [2:0]   mode_next  = sel_l[1] ? wdat_l[`ACC_MODE_HI:`ACC_MODE_LO] : mode_now; // RULE_14
    wire         standby    = ctrl_q[`ACC_STANDBY_BIT];

    // A calibration that ends in the cycle of a restart is discarded
    wire         cal_end    = (state_ff == acc_pkg::ACC_ST_CAL_WAIT) & cal_res_i.done & ~ctrl_hi_wr;
    wire         load_off   = cal_end & ((mode_now == acc_pkg::ACC_MODE_SELF) ||
                                         (mode_now == acc_pkg::ACC_MODE_SYS_OFF)); // RULE_07
    wire         load_fs    = cal_end & ((mode_now == acc_pkg::ACC_MODE_SELF) ||
                                         (mode_now == acc_pkg::ACC_MODE_SYS_FS)); // RULE_11

    acc_byte_reg #(.W(24), .RST(`ACC_CTRL_RST)) u_ctrl ( // RULE_14 RULE_15
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .wr_i       (wr_fire & hit_ctrl),
        .sel_i      (sel_l),
        .wdat_i     (wdat_l),
        .load_i     (1'b0),
        .load_dat_i (24'h000000),
        .q_o        (ctrl_q)
    );

    acc_byte_reg #(.W(24), .RST(`ACC_OFFSET_RST)) u_off ( // RULE_06 RULE_12
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .wr_i       (wr_fire & hit_off),
        .sel_i      (sel_l),
        .wdat_i     (wdat_l),
        .load_i     (load_off),
        .load_dat_i (cal_res_i.offset),
        .q_o        (off_q)
    );

    acc_byte_reg #(.W(24), .RST(`ACC_FS_RST)) u_pos ( // RULE_09
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .wr_i       (wr_fire & hit_pos),
        .sel_i      (sel_l),
        .wdat_i     (wdat_l),
        .load_i     (load_fs),
        .load_dat_i (cal_res_i.pos),
        .q_o        (pos_q)
    );

    acc_byte_reg #(.W(24), .RST(`ACC_FS_RST)) u_neg ( // RULE_10
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .wr_i       (wr_fire & hit_neg),
        .sel_i      (sel_l),
        .wdat_i     (wdat_l),
        .load_i     (load_fs),
        .load_dat_i (cal_res_i.neg),
        .q_o        (neg_q)
    );

    // Correction: subtract offset, then scale by the slope of the result's own sign
    wire signed [24:0] diff   = $signed({raw_i.data[23], raw_i.data}) - $signed({off_q[23], off_q}); // RULE_08
    wire        [23:0] slope  = diff[24] ? neg_q : pos_q; // RULE_09 RULE_10
    wire signed [49:0] prod   = diff * $signed({1'b0, slope});
    wire        [24:0] scaled = prod[FRAC+24:FRAC];
    // Saturate rather than wrap; a wrapped full-scale result would flip sign
    wire               ovf    = scaled[24] ^ scaled[23];
    wire        [23:0] corr   = ovf ? (scaled[24] ? 24'h800000 : 24'h7FFFFF) : scaled[23:0];
    wire               new_res = raw_i.valid & (state_ff == acc_pkg::ACC_ST_RUN) & ~standby & ~ctrl_hi_wr; // RULE_02

    // Calibration sequencer; reset enters it because the mode field resets to self calibration
    always_comb begin
        nxt_state = state_ff;
        if (ctrl_hi_wr) begin
            nxt_state = is_cal(mode_next) ? acc_pkg::ACC_ST_CAL_REQ : acc_pkg::ACC_ST_RUN; // RULE_02
        end else begin
            case (state_ff)
                acc_pkg::ACC_ST_RUN: nxt_state = acc_pkg::ACC_ST_RUN;
                acc_pkg::ACC_ST_CAL_REQ: nxt_state = acc_pkg::ACC_ST_CAL_WAIT;
                acc_pkg::ACC_ST_CAL_WAIT: begin
                    if (cal_res_i.done) begin
                        nxt_state = acc_pkg::ACC_ST_RUN;
                    end
                end
                default: nxt_state = acc_pkg::ACC_ST_RUN;
            endcase
        end
    end

    // Hardware raise on reprogram beats everything; a fresh result beats the read that empties the register
    always_comb begin
        nxt_rvn = rvn_ff;
        if (ctrl_hi_wr || standby) begin
            nxt_rvn = 1'b1; // RULE_01
        end else if (new_res) begin
            nxt_rvn = 1'b0; // RULE_13
        end else if (rd_fire && hit_data) begin
            nxt_rvn = 1'b1;
        end
    end

    wire [23:0] status = {20'h00000, standby, state_ff, rvn_ff};
    wire [23:0] rdat_l = hit_ctrl ? ctrl_q :
                         hit_off  ? off_q :
                         hit_pos  ? pos_q :
                         hit_neg  ? neg_q :
                         hit_data ? result_ff :
                         hit_stat ? status : 24'h000000;
    wire [23:0] rdat_o = byte_order_sel ? swap24(rdat_l) : rdat_l; // RULE_16

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff  <= acc_pkg::ACC_ST_CAL_REQ; // RULE_07 RULE_11
            ack_ff    <= 1'b0;
            dat_ff    <= 32'h00000000;
            result_ff <= 24'h000000;
            rvn_ff    <= 1'b1;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            ack_ff   <= nxt_ack;
            rvn_ff   <= nxt_rvn;
            if (nxt_ack) begin
                dat_ff <= {8'h00, rdat_o};
            end
            if (new_res) begin
                result_ff <= corr; // RULE_06
            end
        end
    end

    assign wb_ack_o         = ack_ff;
    assign wb_dat_o         = dat_ff;
    assign cal_start_o      = (state_ff == acc_pkg::ACC_ST_CAL_REQ);
    assign ctrl_o           = ctrl_q;
    assign result_valid_n_o = rvn_ff;

    chk_ctrl_hi_result_valid_n: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
        (ce_i && ctrl_hi_wr) |=> result_valid_n_o)
        else $error("result valid not raised by upper control write");

    chk_recal_start: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
        (ce_i && ctrl_hi_wr && is_cal(mode_next)) |=> cal_start_o && !new_res)
        else $error("calibration not restarted by upper control write");

    chk_byte0_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
        (ce_i && wr_fire && hit_ctrl && sel_l == 3'b001 && !result_valid_n_o && !standby &&
         !wdat_l[`ACC_STANDBY_BIT] && state_ff == acc_pkg::ACC_ST_RUN)
        |=> !result_valid_n_o && state_ff == acc_pkg::ACC_ST_RUN)
        else $error("byte 0 write disturbed result valid or calibration");

    chk_offset_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
        (ce_i && cal_end && mode_now == acc_pkg::ACC_MODE_SELF) |=> off_q == $past(cal_res_i.offset))
        else $error("offset not loaded from self calibration");

    chk_fs_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
        (ce_i && cal_end && mode_now == acc_pkg::ACC_MODE_SELF)
        |=> pos_q == $past(cal_res_i.pos) && neg_q == $past(cal_res_i.neg))
        else $error("full scale coefficients not loaded from self calibration");

    chk_zero_out: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
        (ce_i && new_res && raw_i.data == off_q) |=> result_ff == 24'h000000)
        else $error("zero input does not give zero output");

    chk_slope_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
        (ce_i && new_res && $signed(raw_i.data) < $signed(off_q)) |-> slope == neg_q)
        else $error("negative result not scaled by negative coefficient");

    chk_result_valid_n_set: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
        (ce_i && new_res) |=> !result_valid_n_o ##1 (!result_valid_n_o || $past(ce_i)))
        else $error("result valid not asserted for new result");

    chk_mode_reset: assert property (@(posedge clk_i) // RULE_14
        $past(rst_i) && !rst_i |-> ctrl_q[`ACC_MODE_HI:`ACC_MODE_LO] == acc_pkg::ACC_MODE_SELF &&
                                  ctrl_q[`ACC_GAIN_HI:`ACC_GAIN_LO] == 3'b000 && cal_start_o)
        else $error("control reset value wrong");

    chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req && !ack_ff) |=> wb_ack_o ##1 (!wb_ack_o || !$past(ce_i)))
        else $error("wishbone ack not a single cycle after request");

    chk_byte0_no_cal: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
        (ce_i && wr_fire && hit_ctrl && sel_l == 3'b001 && state_ff == acc_pkg::ACC_ST_RUN) |=> !cal_start_o)
        else $error("byte 0 write started a calibration");

    chk_cal_no_data: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
        (ce_i && state_ff != acc_pkg::ACC_ST_RUN && result_valid_n_o) |=> result_valid_n_o)
        else $error("result delivered before calibration finished");

    chk_cal_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
        (ce_i && cal_start_o && !ctrl_hi_wr) |=> !cal_start_o)
        else $error("calibration start longer than one cycle");

    chk_offset_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
        (!load_off && !(wr_fire && hit_off)) |=> $stable(off_q))
        else $error("offset coefficient changed without load or write");

    chk_pos_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
        (!load_fs && !(wr_fire && hit_pos)) |=> $stable(pos_q))
        else $error("positive coefficient changed without load or write");

    chk_neg_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
        (!load_fs && !(wr_fire && hit_neg)) |=> $stable(neg_q))
        else $error("negative coefficient changed without load or write");

    chk_sys_off_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
        (ce_i && cal_end && mode_now == acc_pkg::ACC_MODE_SYS_OFF && !(wr_fire && hit_pos))
        |=> off_q == $past(cal_res_i.offset) && $stable(pos_q))
        else $error("system offset calibration loaded the wrong registers");

    chk_sys_fs_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
        (ce_i && cal_end && mode_now == acc_pkg::ACC_MODE_SYS_FS && !(wr_fire && hit_off))
        |=> pos_q == $past(cal_res_i.pos) && neg_q == $past(cal_res_i.neg) && $stable(off_q))
        else $error("system full scale calibration loaded the wrong registers");

    chk_lane_full: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
        (ce_i && wr_fire && hit_off && sel_l == 3'b111 && !load_off) |=> off_q == $past(wdat_l))
        else $error("full offset write not stored");

    chk_lane_byte0: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
        (ce_i && wr_fire && hit_off && sel_l == 3'b001 && !load_off)
        |=> off_q[23:8] == $past(off_q[23:8]) && off_q[7:0] == $past(wdat_l[7:0]))
        else $error("byte 0 offset write touched the wrong lanes");

    chk_order_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
        (ce_i && nxt_ack && hit_off && byte_order_sel)
        |=> wb_dat_o[23:0] == {$past(off_q[7:0]), $past(off_q[15:8]), $past(off_q[23:16])})
        else $error("offset read not in ascending byte order");

    chk_gain_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
        (ce_i && wr_fire && hit_ctrl && sel_l[0])
        |=> ctrl_q[`ACC_GAIN_HI:`ACC_GAIN_LO] == $past(wdat_l[`ACC_GAIN_HI:`ACC_GAIN_LO]))
        else $error("gain field not written from byte 0");

    chk_standby_high: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
        (ce_i && standby) |=> result_valid_n_o)
        else $error("result valid asserted in standby");
endmodule // acc_ctrl_cal

/* tb/acc_cal_model.sv */
// Calibration engine model that answers each start pulse after a set delay
`timescale 1ns/1ps
module acc_cal_model (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             start_i,
    input  wire logic [3:0]       dly_i,
    input  wire logic [71:0]      coef_i,
    output acc_pkg::acc_cal_res_s res_o
);
    logic [3:0] cnt_ff;
    logic       done_ff;
    // Outside the done pulse the values are inverted, so a stale load cannot look right
    assign res_o = {done_ff, done_ff ? coef_i : ~coef_i};
    // A delay of zero would never answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff  <= 4'h0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= (cnt_ff == 4'h1);
            if (start_i) begin
                cnt_ff <= dly_i;
            end else if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule // acc_cal_model

/* tb/tb.sv */
// Self-checking bench for the calibration coefficient and control write block
`timescale 1ns/1ps
`include "acc_regs.svh"
module tb;
    logic                  clk_i = 1'b0, rst_i = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic                  ack, cal_start, rvn, seen;
    logic [7:0]            adr = 8'h00;
    logic [3:0]            sel = 4'h0, dly = 4'h1;
    logic [31:0]           wdat = 32'h00000000, rdat, rd;
    logic [23:0]           ctrl, mo = 24'h000010, mp = 24'h400000, mn = 24'h200000;
    logic [23:0]           eo = 24'h000010, ep = 24'h400000, en = 24'h200000;
    acc_pkg::acc_sample_s  raw = 25'h0000000;
    acc_pkg::acc_cal_res_s cal;
    int                    miscompares = 0, num_checks = 0, cycles = 0;

    acc_cal_model u_cal (.clk_i(clk_i), .rst_i(rst_i), .start_i(cal_start), .dly_i(dly),
                         .coef_i({mo, mp, mn}), .res_o(cal));
    acc_ctrl_cal dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
                      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
                      .raw_i(raw), .cal_res_i(cal), .cal_start_o(cal_start), .ctrl_o(ctrl),
                      .result_valid_n_o(rvn));

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Holds the request until ack is sampled high; a missing ack counts as a mismatch
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) miscompares++;
    endtask

    task automatic cal_done();
        int n;
        n = 0;
        do begin
            wb(1'b0, `ACC_OFS_STATUS, 4'hF, 32'h00000000);
            n++;
        end while (rd[2:1] !== acc_pkg::ACC_ST_RUN && n < 30);
        chk("cal finished", rd[2:1], acc_pkg::ACC_ST_RUN);
    endtask

    task automatic ctl(input logic [3:0] s, input logic [23:0] d);
        wb(1'b1, `ACC_OFS_CTRL, s, {8'h00, d});
        seen = 1'b0;
        repeat (4) begin
            @(negedge clk_i);
            seen |= (cal_start === 1'b1);
        end
    endtask

    task automatic smp(input logic [23:0] v);
        @(posedge clk_i);
        raw <= {1'b1, v};
        @(posedge clk_i);
        raw <= {1'b0, ~v};
        @(negedge clk_i);
    endtask

    function automatic logic [23:0] corr(input logic [23:0] v);
        logic signed [25:0] dif;
        logic signed [51:0] pr;
        dif = $signed({v[23], v[23], v}) - $signed({eo[23], eo[23], eo});
        pr  = dif * $signed({2'b00, dif < 0 ? en : ep});
        return pr[45:22];
    endfunction

    task automatic smp_chk(input logic [23:0] v);
        smp(v);
        chk("valid low", rvn, 1'b0);
        wb(1'b0, `ACC_OFS_DATA, 4'hF, 32'h00000000);
        chk("data", rd, {8'h00, corr(v)});
        @(negedge clk_i);
        chk("valid after read", rvn, 1'b1);
    endtask

    task automatic coef_chk();
        wb(1'b0, `ACC_OFS_OFFSET, 4'hF, 32'h00000000);
        chk("offset", rd, {8'h00, eo});
        wb(1'b0, `ACC_OFS_POS, 4'hF, 32'h00000000);
        chk("pos scale", rd, {8'h00, ep});
        wb(1'b0, `ACC_OFS_NEG, 4'hF, 32'h00000000);
        chk("neg scale", rd, {8'h00, en});
    endtask

    task automatic t_reset();
        chk("mode reset", ctrl[`ACC_MODE_HI:`ACC_MODE_LO], acc_pkg::ACC_MODE_SELF);
        chk("gain reset", ctrl[`ACC_GAIN_HI:`ACC_GAIN_LO], 3'h0);
        chk("valid reset", rvn, 1'b1);
        cal_done();
        coef_chk();
        $display("test reset done");
    endtask

    task automatic t_corr();
        smp_chk(eo);
        smp_chk(24'h000110);
        smp_chk(24'hFFFF10);
        $display("test correction done");
    endtask

    task automatic t_ctrl();
        int m;
        smp(24'h000020);
        ctl(4'h1, 24'h000360);
        chk("byte0 no cal", seen, 1'b0);
        chk("byte0 valid kept", rvn, 1'b0);
        chk("gain written", ctrl, 32'h00000360);
        // Slow engine answers from here on
        dly = 4'h6;
        for (m = 1; m < 4; m++) begin
            mo = mo + 24'h000001;
            mp = mp - 24'h000010;
            mn = mn + 24'h000010;
            smp(24'h000040);
            ctl(4'h7, {12'h000, m[2:0], 9'h160});
            chk("upper write valid high", rvn, 1'b1);
            chk("cal start", seen, 1'b1);
            // This sample lands while the engine still works and must be dropped
            smp(24'h000060);
            cal_done();
            if (m != 3) eo = mo;
            if (m != 2) begin
                ep = mp;
                en = mn;
            end
            coef_chk();
            chk("no data during cal", rvn, 1'b1);
        end
        smp(24'h000050);
        ctl(4'h4, 24'h000000);
        chk("byte2 valid high", rvn, 1'b1);
        chk("byte2 cal start", seen, 1'b1);
        cal_done();
        $display("test control done");
    endtask

    task automatic t_order();
        ctl(4'h7, 24'h000100);
        chk("conv no cal", seen, 1'b0);
        wb(1'b1, `ACC_OFS_OFFSET, 4'h7, 32'h00123456);
        wb(1'b1, `ACC_OFS_OFFSET, 4'h1, 32'h000000AB);
        wb(1'b0, `ACC_OFS_OFFSET, 4'hF, 32'h00000000);
        chk("byte lanes", rd, 32'h001234AB);
        ctl(4'h7, 24'h000104);
        wb(1'b0, `ACC_OFS_OFFSET, 4'hF, 32'h00000000);
        chk("byte order", rd, 32'h00AB3412);
        wb(1'b1, 8'h40, 4'hF, 32'h00FFFFFF);
        wb(1'b0, 8'h40, 4'hF, 32'h00000000);
        chk("unmapped", rd, 32'h00000000);
        $display("test order done");
    endtask

    task automatic t_stby();
        smp(24'h000070);
        ctl(4'h1, 24'h000368);
        chk("standby valid high", rvn, 1'b1);
        chk("standby no cal", seen, 1'b0);
        smp(24'h000070);
        chk("standby drops sample", rvn, 1'b1);
        ctl(4'h1, 24'h000360);
        smp_chk(24'h000110);
        // A sample offered while the clock enable is low must not be taken
        @(posedge clk_i);
        ce <= 1'b0;
        smp(24'h000120);
        chk("frozen valid", rvn, 1'b1);
        @(posedge clk_i);
        ce <= 1'b1;
        $display("test standby done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // The whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        t_reset();
        t_corr();
        t_ctrl();
        t_stby();
        t_order();
        stop_test();
    end
endmodule // tb
